// ==== serial_i2c_bridge.sv ====
/*
  Command interpreter: takes command bytes from the serial side, runs them
  as two-wire bus transfers as controller, and answers on the serial side.
  Assumes a byte stream with valid/ready handshakes on both serial directions.
*/
// Contract
// - Write request: 02 00 57 41 address register length data
// - After write completes, answer 4f then 4b
// - Read request: 02 00 52 44 address length
// - After read, return exactly length fetched bytes
// - Write payload reaches target before completion is reported
`timescale 1ns/1ps
module serial_i2c_bridge #(
  parameter int QUARTER_CYC = bridge_pkg::QUARTER_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] rxData,
  input  wire logic       rxValid,
  output logic            rxReady,
  output logic [7:0]      txData,
  output logic            txValid,
  input  wire logic       txReady,
  input  wire logic       sclIn,
  output logic            sclOut,
  output logic            sclOe,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe
);
  typedef enum logic [4:0] {
    S_INDEX, S_ROLE, S_LET1, S_WLET2, S_RLET2, S_ADDR, S_REG, S_LEN,
    S_START, S_ADDRTX, S_REGTX, S_PAYRX, S_PAYTX, S_RDBYTE, S_RDOUT,
    S_STOP, S_ANS1, S_ANS2
  } cmd_state_t;

  cmd_state_t state_r;
  logic       isRead_r;
  logic [6:0] busPeerAddress_r;
  logic [7:0] peerRegisterOffset_r;
  logic [7:0] remain_r;
  logic [7:0] data_r;
  logic [7:0] txData_r;
  logic       waiting_r;
  logic       busState;
  logic       rxTake;
  logic       opDone;

  bus_op_if busOp ();

  i2c_byte_engine #(
    .QUARTER_CYC (QUARTER_CYC)
  ) engine (
    .core_clk (core_clk),
    .rst      (rst),
    .busOp    (busOp),
    .sclIn    (sclIn),
    .sclOut   (sclOut),
    .sclOe    (sclOe),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe)
  );

  assign busState = (state_r == S_START) || (state_r == S_ADDRTX) || (state_r == S_REGTX)
                 || (state_r == S_PAYTX) || (state_r == S_RDBYTE) || (state_r == S_STOP);
  assign opDone   = busState && waiting_r && busOp.done;

  // Serial input is only taken while parsing or awaiting a payload byte, so the host is stalled during bus work
  always_comb begin
    case (state_r)
      S_INDEX, S_ROLE, S_LET1, S_WLET2, S_RLET2, S_ADDR, S_REG, S_LEN, S_PAYRX:
        rxReady = 1'b1;
      default:
        rxReady = 1'b0;
    endcase
  end
  assign rxTake  = rxReady && rxValid;
  assign txValid = (state_r == S_RDOUT) || (state_r == S_ANS1) || (state_r == S_ANS2);
  assign txData  = txData_r;

  always_comb begin
    busOp.valid  = busState && !waiting_r;
    busOp.wrByte = data_r;
    busOp.ackOut = 1'b0;
    case (state_r)
      S_START:  busOp.op = bridge_pkg::OP_START;
      S_STOP:   busOp.op = bridge_pkg::OP_STOP;
      S_RDBYTE: begin
        busOp.op     = bridge_pkg::OP_READ;
        busOp.ackOut = (remain_r != 8'h01);
      end
      default:  busOp.op = bridge_pkg::OP_WRITE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      waiting_r <= 1'b0;
    end else if (busOp.valid) begin
      waiting_r <= 1'b1;
    end else if (busOp.done) begin
      waiting_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r              <= S_INDEX;
      isRead_r             <= 1'b0;
      busPeerAddress_r     <= 7'h00;
      peerRegisterOffset_r <= 8'h00;
      remain_r             <= 8'h00;
      data_r               <= 8'h00;
      txData_r             <= 8'h00;
    end else begin
      case (state_r)
        S_INDEX: if (rxTake && rxData == bridge_pkg::IFACE_INDEX) state_r <= S_ROLE;
        S_ROLE: if (rxTake) begin
          state_r <= (rxData == bridge_pkg::ROLE_CTRL) ? S_LET1 : S_INDEX;
        end
        S_LET1: if (rxTake) begin
          if (rxData == bridge_pkg::CMD_W) state_r <= S_WLET2;
          else if (rxData == bridge_pkg::CMD_R) state_r <= S_RLET2;
          else state_r <= S_INDEX;
        end
        S_WLET2: if (rxTake) begin
          isRead_r <= 1'b0;
          state_r  <= (rxData == bridge_pkg::CMD_A) ? S_ADDR : S_INDEX;
        end
        S_RLET2: if (rxTake) begin
          isRead_r <= 1'b1;
          state_r  <= (rxData == bridge_pkg::CMD_D) ? S_ADDR : S_INDEX;
        end
        S_ADDR: if (rxTake) begin
          busPeerAddress_r <= rxData[6:0];
          state_r          <= isRead_r ? S_LEN : S_REG;
        end
        S_REG: if (rxTake) begin
          peerRegisterOffset_r <= rxData;
          state_r              <= S_LEN;
        end
        S_LEN: if (rxTake) begin
          remain_r <= rxData;
          data_r   <= {busPeerAddress_r, isRead_r ? bridge_pkg::DIR_READ : bridge_pkg::DIR_WRITE};
          state_r  <= S_START;
        end
        S_START: if (opDone) state_r <= S_ADDRTX;
        S_ADDRTX: if (opDone) begin
          // A refused address still runs to the stop so the bus is left idle
          if (isRead_r) begin
            state_r <= (remain_r == 8'h00) ? S_STOP : S_RDBYTE;
          end else begin
            data_r  <= peerRegisterOffset_r;
            state_r <= S_REGTX;
          end
        end
        S_REGTX: if (opDone) state_r <= (remain_r == 8'h00) ? S_STOP : S_PAYRX;
        S_PAYRX: if (rxTake) begin
          data_r   <= rxData;
          remain_r <= remain_r - 8'h01;
          state_r  <= S_PAYTX;
        end
        S_PAYTX: if (opDone) state_r <= (remain_r == 8'h00) ? S_STOP : S_PAYRX;
        S_RDBYTE: if (opDone) begin
          txData_r <= busOp.rdByte;
          remain_r <= remain_r - 8'h01;
          state_r  <= S_RDOUT;
        end
        S_RDOUT: if (txReady) state_r <= (remain_r == 8'h00) ? S_STOP : S_RDBYTE;
        S_STOP: if (opDone) begin
          if (isRead_r) begin
            state_r <= S_INDEX;
          end else begin
            txData_r <= bridge_pkg::ANS_FIRST;
            state_r  <= S_ANS1;
          end
        end
        S_ANS1: if (txReady) begin
          txData_r <= bridge_pkg::ANS_SECOND;
          state_r  <= S_ANS2;
        end
        S_ANS2: if (txReady) state_r <= S_INDEX;
        default: state_r <= S_INDEX;
      endcase
    end
  end
endmodule

// ==== bridge_pkg.sv ====
/*
  Shared constants for the serial-command to two-wire-bus bridge:
  command byte codes, answer codes, bus operation codes and bit timing.
  Assumes a 125 MHz core clock.
*/
package bridge_pkg;
  localparam logic [7:0] IFACE_INDEX  = 8'h02;
  localparam logic [7:0] ROLE_CTRL    = 8'h00;
  localparam logic [7:0] CMD_W        = 8'h57;
  localparam logic [7:0] CMD_A        = 8'h41;
  localparam logic [7:0] CMD_R        = 8'h52;
  localparam logic [7:0] CMD_D        = 8'h44;
  localparam logic [7:0] ANS_FIRST    = 8'h4f;
  localparam logic [7:0] ANS_SECOND   = 8'h4b;
  localparam logic       DIR_WRITE    = 1'b0;
  localparam logic       DIR_READ     = 1'b1;
  // Quarter of a 100 kHz bus bit, rounded down to whole cycles
  localparam int         CLK_MHZ      = 125;
  localparam int         QUARTER_NS   = 2500;
  localparam int         QUARTER_CYC  = QUARTER_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    OP_START,
    OP_WRITE,
    OP_READ,
    OP_STOP
  } bus_op_t;
endpackage

// ==== bus_op_if.sv ====
/*
  Carrier between the command interpreter and the byte engine.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface bus_op_if;
  logic                  valid;
  bridge_pkg::bus_op_t   op;
  logic [7:0]            wrByte;
  logic                  ackOut;
  logic                  done;
  logic [7:0]            rdByte;
  logic                  nack;
  modport ctrl (output valid, op, wrByte, ackOut, input done, rdByte, nack);
  modport engine (input valid, op, wrByte, ackOut, output done, rdByte, nack);
endinterface

// ==== i2c_byte_engine.sv ====
/*
  Two-wire bus controller engine: start, one byte out, one byte in, stop.
  Assumes open-drain pads outside; an enable high pulls the line low.
*/
`timescale 1ns/1ps
module i2c_byte_engine #(
  parameter int QUARTER_CYC = bridge_pkg::QUARTER_CYC
) (
  input  wire logic  core_clk,
  input  wire logic  rst,
  bus_op_if.engine   busOp,
  input  wire logic  sclIn,
  output logic       sclOut,
  output logic       sclOe,
  input  wire logic  sdaIn,
  output logic       sdaOut,
  output logic       sdaOe
);
  typedef enum logic [1:0] {E_IDLE, E_START, E_BIT, E_STOP} eng_state_t;

  eng_state_t  state_r;
  logic [1:0]  phase_r;
  logic [3:0]  bit_r;
  logic [7:0]  shift_r;
  logic        isRead_r;
  logic        ackOut_r;
  logic        nack_r;
  logic        done_r;
  logic        sclOe_r;
  logic        sdaOe_r;
  logic [15:0] cnt_r;
  logic        tick;
  logic [2:0]  sclSync_r;
  logic [2:0]  sdaSync_r;
  logic        sclF_r;
  logic        sdaF_r;

  // Three-stage input capture; a level counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclSync_r <= 3'h7;
      sdaSync_r <= 3'h7;
      sclF_r    <= 1'b1;
      sdaF_r    <= 1'b1;
    end else begin
      sclSync_r <= {sclSync_r[1:0], sclIn};
      sdaSync_r <= {sdaSync_r[1:0], sdaIn};
      if (sclSync_r[1] == sclSync_r[2]) sclF_r <= sclSync_r[2];
      if (sdaSync_r[1] == sdaSync_r[2]) sdaF_r <= sdaSync_r[2];
    end
  end

  assign tick = (state_r != E_IDLE) && (cnt_r == 16'(QUARTER_CYC - 1));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
    end else if (state_r == E_IDLE || tick) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r  <= E_IDLE;
      phase_r  <= 2'h0;
      bit_r    <= 4'h0;
      shift_r  <= 8'h00;
      isRead_r <= 1'b0;
      ackOut_r <= 1'b0;
      nack_r   <= 1'b0;
      done_r   <= 1'b0;
      sclOe_r  <= 1'b0;
      sdaOe_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        E_IDLE: begin
          if (busOp.valid) begin
            phase_r  <= 2'h0;
            bit_r    <= 4'h0;
            shift_r  <= busOp.wrByte;
            isRead_r <= (busOp.op == bridge_pkg::OP_READ);
            ackOut_r <= busOp.ackOut;
            case (busOp.op)
              bridge_pkg::OP_START: state_r <= E_START;
              bridge_pkg::OP_STOP:  state_r <= E_STOP;
              default:              state_r <= E_BIT;
            endcase
          end
        end
        E_START: if (tick) begin
          phase_r <= phase_r + 2'h1;
          case (phase_r)
            2'h0: begin
              sdaOe_r <= 1'b0;
              sclOe_r <= 1'b0;
            end
            2'h1: sdaOe_r <= 1'b1;
            2'h2: sclOe_r <= 1'b1;
            default: begin
              done_r  <= 1'b1;
              state_r <= E_IDLE;
            end
          endcase
        end
        E_BIT: if (tick) begin
          case (phase_r)
            2'h0: begin
              phase_r <= 2'h1;
              if (bit_r < 4'h8) sdaOe_r <= isRead_r ? 1'b0 : ~shift_r[7];
              else sdaOe_r <= isRead_r ? ackOut_r : 1'b0;
            end
            2'h1: begin
              phase_r <= 2'h2;
              sclOe_r <= 1'b0;
            end
            2'h2: begin
              // Hold here while the target stretches the clock
              if (sclF_r) begin
                phase_r <= 2'h3;
                if (bit_r < 4'h8) shift_r <= {shift_r[6:0], sdaF_r};
                else nack_r <= sdaF_r;
              end
            end
            default: begin
              phase_r <= 2'h0;
              sclOe_r <= 1'b1;
              bit_r   <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                done_r  <= 1'b1;
                state_r <= E_IDLE;
              end
            end
          endcase
        end
        E_STOP: if (tick) begin
          case (phase_r)
            2'h0: begin
              phase_r <= 2'h1;
              sdaOe_r <= 1'b1;
            end
            2'h1: begin
              phase_r <= 2'h2;
              sclOe_r <= 1'b0;
            end
            2'h2: begin
              if (sclF_r) begin
                phase_r <= 2'h3;
                sdaOe_r <= 1'b0;
              end
            end
            default: begin
              done_r  <= 1'b1;
              state_r <= E_IDLE;
            end
          endcase
        end
        default: state_r <= E_IDLE;
      endcase
    end
  end

  assign sclOut       = 1'b0;
  assign sdaOut       = 1'b0;
  assign sclOe        = sclOe_r;
  assign sdaOe        = sdaOe_r;
  assign busOp.done   = done_r;
  assign busOp.rdByte = shift_r;
  assign busOp.nack   = nack_r;
endmodule

// ==== serial_i2c_bridge_assertions.sv ====
/*
  Port checker for the serial to two-wire bridge.
  Assumes QUARTER_CYC matches the bound design; start windows scale with it.
*/
`timescale 1ns/1ps
module serial_i2c_bridge_assertions #(
  parameter int QUARTER_CYC = 4
) (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] rxData,
  input wire logic       rxValid,
  input wire logic       rxReady,
  input wire logic [7:0] txData,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic       sclIn,
  input wire logic       sclOut,
  input wire logic       sclOe,
  input wire logic       sdaIn,
  input wire logic       sdaOut,
  input wire logic       sdaOe
);
  // Clock falls exactly one quarter after data in a start; one cycle of slack
  localparam int START_WIN = QUARTER_CYC + 1;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  tx_stand_a: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("answer byte dropped while stalled");
  // Read bytes are offered with the clock held low, answers only once the bus is free
  ans_order_a: assert property (txValid && txReady && !sclOe &&
    txData == bridge_pkg::ANS_FIRST |=> txValid && txData == bridge_pkg::ANS_SECOND)
    else $error("second answer byte missing");
  ans_done_a: assert property (txValid && txReady && !sclOe &&
    txData == bridge_pkg::ANS_SECOND |=> !txValid) else $error("extra answer byte");
  ans_bus_idle_a: assert property ($rose(txValid) && !sclOe |->
    txData == bridge_pkg::ANS_FIRST && !sdaOe) else $error("answer before stop");
  start_hold_a: assert property ($rose(sdaOe) && !sclOe |->
    sdaOe throughout (##[1:START_WIN] sclOe)) else $error("start not followed by clock");
  stop_idle_a: assert property ($fell(sdaOe) && !sclOe |=> (!sdaOe && !sclOe) [*3])
    else $error("bus not idle after stop");
  open_drain_a: assert property (sclOut == 1'b0 && sdaOut == 1'b0)
    else $error("pad level not low");
  rx_tx_excl_a: assert property (rxValid && rxReady |-> !txValid)
    else $error("command taken while answering");

  cover property (txValid && txReady && txData == bridge_pkg::ANS_SECOND);
  cover property ($rose(sdaOe) && !sclOe);
  cover property (rxValid && rxReady && rxData == bridge_pkg::CMD_D);
endmodule

bind serial_i2c_bridge serial_i2c_bridge_assertions #(.QUARTER_CYC(QUARTER_CYC)) u_chk (
  .core_clk(core_clk), .rst(rst), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
  .txData(txData), .txValid(txValid), .txReady(txReady), .sclIn(sclIn), .sclOut(sclOut),
  .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ==== i2c_peer_model.sv ====
/*
  Behavioural bus target: logs written bytes, ACKs them, returns a0, a1, ...
  Assumes pull-ups on both lines; stretchEn holds the clock low after each fall.
*/
`timescale 1ns/1ps
module i2c_peer_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic stretchEn,
  output logic      sclPull,
  output logic      sdaPull
);
  logic [7:0] got[$];
  logic [7:0] sh;
  logic [7:0] rdByte;
  logic       rdPhase;
  logic       first;
  int         bitCnt;
  int         rdIdx;
  int         stops;

  initial begin
    sclPull = 1'b0;
    sdaPull = 1'b0;
    rdPhase = 1'b0;
    first = 1'b0;
    bitCnt = 0;
    rdIdx = 0;
    stops = 0;
  end
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitCnt = 0;
      rdPhase = 1'b0;
      first = 1'b1;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) stops++;
  end
  always @(posedge scl) begin
    if (bitCnt < 8) sh = {sh[6:0], sda};
    else if (rdPhase && sda) rdPhase = 1'b0;
    bitCnt++;
  end
  always @(negedge scl) begin
    if (bitCnt == 8 && !rdPhase) begin
      got.push_back(sh);
      if (first) rdPhase = sh[0];
      first = 1'b0;
      sdaPull = 1'b1;
    end else if (bitCnt == 8) begin
      sdaPull = 1'b0;
    end else if (bitCnt >= 9) begin
      bitCnt = 0;
      rdByte = 8'ha0 + 8'(rdIdx);
      if (rdPhase) rdIdx++;
      sdaPull = rdPhase & ~rdByte[7];
    end else if (rdPhase) begin
      sdaPull = ~rdByte[7 - bitCnt];
    end
    // Slow target: proves the controller waits for the clock line
    if (stretchEn) begin
      sclPull = 1'b1;
      #100 sclPull = 1'b0;
    end
  end
endmodule

// ==== usb_serial_to_i2c_commands_tb_top.sv ====
/*
  Testbench for the bridge: host byte stream driven here, bus target modelled.
  Assumes QUARTER_CYC of 4 and pull-ups on both bus lines.
*/
`timescale 1ns/1ps
module usb_serial_to_i2c_commands_tb_top;
  localparam int QC = 4;
  localparam int LIM = 4000;
  logic       core_clk;
  logic       rst;
  logic       rxValid;
  logic       txReady;
  logic       stretchEn;
  logic [7:0] rxData;
  wire logic  rxReady, txValid, sclOut, sclOe, sdaOut, sdaOe, sclPull, sdaPull;
  wire logic  sclLine, sdaLine;
  wire logic [7:0] txData;
  int         errors;
  int         checkCount;

  assign sclLine = ~sclOe & ~sclPull;
  assign sdaLine = ~sdaOe & ~sdaPull;

  serial_i2c_bridge #(.QUARTER_CYC(QC)) i_dut (
    .core_clk(core_clk), .rst(rst), .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .txData(txData), .txValid(txValid), .txReady(txReady), .sclIn(sclLine), .sclOut(sclOut),
    .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe));
  i2c_peer_model i_peer (.scl(sclLine), .sda(sdaLine), .stretchEn(stretchEn),
    .sclPull(sclPull), .sdaPull(sdaPull));

  task automatic final_report();
    $display("errors %0d checks %0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic timeout();
    errors++;
    final_report();
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic [7:0] q[$]);
    int n;
    foreach (q[i]) begin
      rxData = q[i];
      rxValid = 1'b1;
      n = 0;
      while (rxReady !== 1'b1) begin
        @(posedge core_clk);
        #1;
        n++;
        if (n > LIM) timeout();
      end
      @(posedge core_clk);
      #1;
    end
    rxValid = 1'b0;
  endtask
  // Host stalls two cycles before taking each answer byte
  task automatic take(input logic [7:0] exp, input string what);
    int n;
    n = 0;
    while (txValid !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > LIM) timeout();
    end
    repeat (2) @(posedge core_clk);
    #1;
    chk({what, " valid"}, 8'h01, {7'h00, txValid});
    chk(what, exp, txData);
    txReady = 1'b1;
    @(posedge core_clk);
    #1;
    txReady = 1'b0;
  endtask
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (txValid !== 1'b0) seen = 1'b1;
    end
    chk("unexpected answer", 8'h00, {7'h00, seen});
  endtask

  task automatic write_reg();
    int stops;
    logic [7:0] exp[$];
    exp = '{8'hfc, 8'h01, 8'h10, 8'h11, 8'h12};
    stretchEn = 1'b1;
    i_peer.got.delete();
    stops = i_peer.stops;
    send('{8'h02, 8'h00, 8'h57, 8'h41, 8'h7e, 8'h01, 8'h03, 8'h10, 8'h11, 8'h12});
    take(8'h4f, "ack first");
    chk("stops", 8'(stops + 1), 8'(i_peer.stops));
    take(8'h4b, "ack second");
    quiet(50);
    chk("peer count", 8'h05, 8'(i_peer.got.size()));
    foreach (exp[i]) chk("peer byte", exp[i], i_peer.got[i]);
  endtask
  task automatic read_direct();
    stretchEn = 1'b0;
    i_peer.got.delete();
    i_peer.rdIdx = 0;
    send('{8'h02, 8'h00, 8'h52, 8'h44, 8'h7e, 8'h02});
    take(8'ha0, "read 0");
    take(8'ha1, "read 1");
    quiet(300);
    chk("read address", 8'hfd, i_peer.got[0]);
  endtask
  task automatic bad_then_empty();
    i_peer.got.delete();
    send('{8'h02, 8'h00, 8'h57, 8'h00});
    quiet(200);
    chk("bus after bad", 8'h00, 8'(i_peer.got.size()));
    send('{8'h02, 8'h00, 8'h52, 8'h44, 8'h7e, 8'h00});
    quiet(400);
    chk("empty read", 8'h01, 8'(i_peer.got.size()));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1;
    rxValid = 1'b0;
    rxData = 8'h00;
    txReady = 1'b0;
    stretchEn = 1'b0;
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    write_reg();
    read_direct();
    bad_then_empty();
    final_report();
  end
endmodule
